/* rtl/phdc_cfg.svh */
// constants for the printhead drive control block
// assumes inclusion by the package, the top module, the far-side model and the bench
`ifndef PHDC_CFG_SVH
`define PHDC_CFG_SVH
`define PHDC_ADDR_W 5
`define PHDC_ROWS 6
`define PHDC_ROW_BITS 96
`define PHDC_WAVE_BITS 16
`define PHDC_SYNC_INIT 1'b0
`endif

/* rtl/phdc_pkg.sv */
// types for the printhead drive control block
// assumes phdc_cfg.svh is on the include path
`include "phdc_cfg.svh"
package phdc_pkg;
    typedef enum logic [2:0] {
        PHDC_OP_NONE = 3'h0,
        PHDC_OP_WRITE = 3'h1,
        PHDC_OP_FIRE = 3'h2,
        PHDC_OP_ROW = 3'h4
    } phdc_op_t;

    typedef enum logic [5:0] {
        PHDC_ST_IDLE = 6'h01,
        PHDC_ST_SHIFT = 6'h02,
        PHDC_ST_LATCH = 6'h04,
        PHDC_ST_PULSE_ONE = 6'h08,
        PHDC_ST_PULSE_TWO = 6'h10,
        PHDC_ST_DONE = 6'h20
    } phdc_state_t;

    typedef struct packed {
        phdc_op_t op;
        logic [`PHDC_ADDR_W-1:0] addr;
    } phdc_cmd_t;

    typedef struct packed {
        logic [`PHDC_ADDR_W-1:0] waveform_address;
        logic waveform_clock_one;
        logic waveform_clock_two;
        logic clear;
        logic baseline_select;
        logic data;
    } phdc_common_t;

    typedef struct packed {
        logic [`PHDC_ROWS-1:0] nozzle_row_serial;
        logic shift_clock;
        logic row_load_strobe;
    } phdc_nozzle_t;
endpackage

/* rtl/phdc_top.sv */
// printhead drive control: requests on clk_i, pins on the link clock
// assumes link_clk_i runs free and the far ICs sample on rising clocks
`timescale 1ns/1ns
`default_nettype none
`include "phdc_cfg.svh"
// Notes on behaviour
// - ten lines drive the common driver
// - waveform data sent serially on data line
// - address lines pick the memory location
// - six row streams on six serial lines
// - row transfer follows shift clock and strobe
module phdc_top
    import phdc_pkg::*;
#(
    parameter int ROW_BITS = `PHDC_ROW_BITS,
    parameter int WAVE_BITS = `PHDC_WAVE_BITS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic wave_write_i,
    input wire logic [`PHDC_ADDR_W-1:0] wave_addr_i,
    input wire logic [WAVE_BITS-1:0] wave_data_i,
    input wire logic wave_fire_i,
    input wire logic row_load_i,
    input wire logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] row_data_i,
    input wire logic clear_i,
    input wire logic baseline_i,
    output logic ready_o,
    output phdc_common_t common_o,
    output phdc_nozzle_t nozzle_o
);
    localparam int MAXB = (ROW_BITS > WAVE_BITS) ? ROW_BITS : WAVE_BITS;
    localparam int CW = $clog2(MAXB + 1);

    if (ROW_BITS < 2 || WAVE_BITS < 2 || ROW_BITS > 4096 || WAVE_BITS > 4096) begin : g_chk
        $error("phdc_top: bit counts out of range");
    end

    // ---------------- request side (clk_i) ----------------
    logic busy;
    logic req_tgl;
    logic ack_s1, ack_s2;
    logic clr_q, base_q;
    phdc_cmd_t cmd_q;
    logic [WAVE_BITS-1:0] wave_q;
    logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] rows_q;
    logic ack_tgl;

    wire any_req = wave_write_i | wave_fire_i | row_load_i;
    wire start = any_req & ~busy;
    wire done_seen = busy & (ack_s2 == req_tgl);
    wire phdc_op_t next_op = row_load_i ? PHDC_OP_ROW :
                             wave_write_i ? PHDC_OP_WRITE : PHDC_OP_FIRE;

    always_ff @(posedge clk_i) begin
        ack_s1 <= ack_tgl;
        ack_s2 <= ack_s1;
        clr_q <= clear_i;
        base_q <= baseline_i;
        if (start) begin
            cmd_q.op <= next_op;
            cmd_q.addr <= wave_addr_i;
            wave_q <= wave_data_i;
            rows_q <= row_data_i;
        end
        if (!rst_n_i) begin
            busy <= 1'b0;
            req_tgl <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            busy <= start | (busy & ~done_seen);
            req_tgl <= req_tgl ^ start;
            ready_o <= ~(start | (busy & ~done_seen));
        end
    end

    // ---------------- link side (link_clk_i) ----------------
    logic lrst_s1, lrst_n;
    logic req_s1, req_s2, req_seen;
    logic clr_s1, clr_s2, base_s1, base_s2;
    phdc_state_t st;
    phdc_op_t op;
    logic ph;
    logic [CW-1:0] cnt;
    logic [CW-1:0] sent;
    logic [WAVE_BITS-1:0] wave_sh;
    logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] row_sh;
    logic [`PHDC_ADDR_W-1:0] cur_addr;

    wire new_req = req_s2 != req_seen;
    wire is_row = op == PHDC_OP_ROW;
    wire last_bit = ph & (cnt == CW'(1));
    wire [`PHDC_ROWS-1:0] row_msb;
    for (genvar r = 0; r < `PHDC_ROWS; r++) begin : g_msb
        assign row_msb[r] = row_sh[r][ROW_BITS-1];
    end

    always_ff @(posedge link_clk_i) begin
        lrst_s1 <= rst_n_i;
        lrst_n <= lrst_s1;
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        clr_s1 <= clr_q;
        clr_s2 <= clr_s1;
        base_s1 <= base_q;
        base_s2 <= base_s1;
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            st <= PHDC_ST_IDLE;
            op <= PHDC_OP_NONE;
            req_seen <= `PHDC_SYNC_INIT;
            ack_tgl <= 1'b0;
            ph <= 1'b0;
            cnt <= '0;
            sent <= '0;
            wave_sh <= '0;
            row_sh <= '0;
            cur_addr <= '0;
            common_o <= '0;
            nozzle_o <= '0;
        end else begin
            common_o.clear <= clr_s2;
            common_o.baseline_select <= base_s2;
            case (st)
                PHDC_ST_IDLE: begin
                    common_o.waveform_clock_one <= 1'b0;
                    common_o.waveform_clock_two <= 1'b0;
                    nozzle_o.shift_clock <= 1'b0;
                    nozzle_o.row_load_strobe <= 1'b0;
                    if (new_req) begin
                        req_seen <= req_s2;
                        op <= cmd_q.op;
                        cur_addr <= cmd_q.addr;
                        wave_sh <= wave_q;
                        row_sh <= rows_q;
                        sent <= '0;
                        ph <= 1'b0;
                        if (cmd_q.op == PHDC_OP_ROW) begin
                            cnt <= CW'(ROW_BITS);
                            st <= PHDC_ST_SHIFT;
                        end else if (cmd_q.op == PHDC_OP_WRITE) begin
                            cnt <= CW'(WAVE_BITS);
                            common_o.waveform_address <= cmd_q.addr;
                            st <= PHDC_ST_SHIFT;
                        end else begin
                            st <= PHDC_ST_PULSE_ONE;
                        end
                    end
                end
                PHDC_ST_SHIFT: begin
                    ph <= ~ph;
                    if (!ph) begin
                        // set the bit up with the clock low
                        if (is_row) begin
                            nozzle_o.nozzle_row_serial <= row_msb;
                            nozzle_o.shift_clock <= 1'b0;
                        end else begin
                            common_o.data <= wave_sh[WAVE_BITS-1];
                            common_o.waveform_clock_one <= 1'b0;
                        end
                    end else begin
                        // rising clock: far side samples the bit
                        if (is_row) begin
                            nozzle_o.shift_clock <= 1'b1;
                            for (int r = 0; r < `PHDC_ROWS; r++) begin
                                row_sh[r] <= {row_sh[r][ROW_BITS-2:0], 1'b0};
                            end
                        end else begin
                            common_o.waveform_clock_one <= 1'b1;
                            wave_sh <= {wave_sh[WAVE_BITS-2:0], 1'b0};
                        end
                        sent <= sent + CW'(1);
                        cnt <= cnt - CW'(1);
                        if (last_bit) begin
                            st <= is_row ? PHDC_ST_LATCH : PHDC_ST_DONE;
                        end
                    end
                end
                PHDC_ST_LATCH: begin
                    nozzle_o.shift_clock <= 1'b0;
                    nozzle_o.row_load_strobe <= 1'b1;
                    st <= PHDC_ST_DONE;
                end
                PHDC_ST_PULSE_ONE: begin
                    common_o.waveform_clock_one <= 1'b1;
                    st <= PHDC_ST_PULSE_TWO;
                end
                PHDC_ST_PULSE_TWO: begin
                    common_o.waveform_clock_one <= 1'b0;
                    common_o.waveform_clock_two <= 1'b1;
                    st <= PHDC_ST_DONE;
                end
                PHDC_ST_DONE: begin
                    common_o.waveform_clock_one <= 1'b0;
                    common_o.waveform_clock_two <= 1'b0;
                    nozzle_o.shift_clock <= 1'b0;
                    nozzle_o.row_load_strobe <= 1'b0;
                    ack_tgl <= ~ack_tgl;
                    st <= PHDC_ST_IDLE;
                end
                default: begin
                    st <= PHDC_ST_IDLE;
                end
            endcase
        end
    end

    // ---------------- checks ----------------
    sequence s_pulse_one;
        common_o.waveform_clock_one && !common_o.waveform_clock_two;
    endsequence
    sequence s_pulse_two;
        !common_o.waveform_clock_one && common_o.waveform_clock_two ##1
            !common_o.waveform_clock_two;
    endsequence

    property p_fire_order;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (st == PHDC_ST_PULSE_ONE) |=> s_pulse_one ##1 s_pulse_two;
    endproperty
    a_fire_order: assert property (p_fire_order) else $error("clock pair out of order");

    property p_addr_held;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (st == PHDC_ST_SHIFT && op == PHDC_OP_WRITE && ph)
            |-> common_o.waveform_address == cur_addr;
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved during write");

    property p_wave_bit;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $rose(common_o.waveform_clock_one) && op == PHDC_OP_WRITE |-> $stable(common_o.data);
    endproperty
    a_wave_bit: assert property (p_wave_bit) else $error("data changed on clock edge");

    property p_row_bit;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $rose(nozzle_o.shift_clock) |-> $stable(nozzle_o.nozzle_row_serial);
    endproperty
    a_row_bit: assert property (p_row_bit) else $error("row data changed on shift edge");

    property p_strobe_full;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $rose(nozzle_o.row_load_strobe) |-> sent == CW'(ROW_BITS);
    endproperty
    a_strobe_full: assert property (p_strobe_full) else $error("strobe before full row");

    property p_strobe_shape;
        @(posedge link_clk_i) disable iff (!lrst_n)
        nozzle_o.row_load_strobe |-> !nozzle_o.shift_clock ##1 !nozzle_o.row_load_strobe;
    endproperty
    a_strobe_shape: assert property (p_strobe_shape) else $error("strobe overlaps shift clock");

    property p_clear_follow;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $changed(clr_s2) |=> common_o.clear == $past(clr_s2);
    endproperty
    a_clear_follow: assert property (p_clear_follow) else $error("clear line not following");

    property p_busy_after_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        start |=> !ready_o ##1 !ready_o;
    endproperty
    a_busy_after_start: assert property (p_busy_after_start) else $error("ready after start");
endmodule
`default_nettype wire

/* testbench/phdc_far_model.sv */
// far-side model: common driver waveform word and address, and nozzle selector rows
// assumes the pins of phdc_top arrive unchanged and are sampled on rising clocks
`timescale 1ns/1ns
`default_nettype none
`include "phdc_cfg.svh"
module phdc_far_model
    import phdc_pkg::*;
#(
    parameter int ROW_BITS = 8,
    parameter int WAVE_BITS = 4
) (
    input wire phdc_common_t common_i,
    input wire phdc_nozzle_t nozzle_i,
    output logic [WAVE_BITS-1:0] word_o,
    output logic [`PHDC_ADDR_W-1:0] addr_o,
    output logic [15:0] pulse_one_cnt_o,
    output logic [15:0] pulse_two_cnt_o,
    output logic [15:0] shift_cnt_o,
    output logic [15:0] load_cnt_o,
    output logic [15:0] bits_at_load_o,
    output logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] rows_o
);
    logic [WAVE_BITS-1:0] word = '0;
    logic [`PHDC_ADDR_W-1:0] addr = '0;
    logic [15:0] n_one = '0;
    logic [15:0] n_two = '0;
    logic [15:0] n_shift = '0;
    logic [15:0] n_load = '0;
    logic [15:0] shift_at_load = '0;
    logic [15:0] bits_at_load = '0;
    logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] shreg = '0;
    logic [`PHDC_ROWS-1:0][ROW_BITS-1:0] rows = '0;
    assign word_o = word;
    assign addr_o = addr;
    assign pulse_one_cnt_o = n_one;
    assign pulse_two_cnt_o = n_two;
    assign shift_cnt_o = n_shift;
    assign load_cnt_o = n_load;
    assign bits_at_load_o = bits_at_load;
    assign rows_o = rows;
    // word shifted in from the data line; address lines captured on each rising clock one
    always @(posedge common_i.waveform_clock_one) begin
        word <= {word[WAVE_BITS-2:0], common_i.data};
        addr <= common_i.waveform_address;
        n_one <= n_one + 16'h1;
    end
    // rising edges of clock two are counted
    always @(posedge common_i.waveform_clock_two) begin
        n_two <= n_two + 16'h1;
    end
    // six rows shift in parallel on the shift clock
    always @(posedge nozzle_i.shift_clock) begin
        for (int r = 0; r < `PHDC_ROWS; r++) begin
            shreg[r] <= {shreg[r][ROW_BITS-2:0], nozzle_i.nozzle_row_serial[r]};
        end
        n_shift <= n_shift + 16'h1;
    end
    // whole pattern taken as one nozzle selection
    always @(posedge nozzle_i.row_load_strobe) begin
        rows <= shreg;
        bits_at_load <= n_shift - shift_at_load;
        shift_at_load <= n_shift;
        n_load <= n_load + 16'h1;
    end
endmodule
`default_nettype wire

/* testbench/test_phdc_top.sv */
// self-checking bench for phdc_top with the far-side model on its pins
// assumes phdc_far_model and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "phdc_cfg.svh"
module test_phdc_top
    import phdc_pkg::*;
;
    localparam int RB = 8;
    localparam int WB = 4;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wave_write_i = 1'b0;
    logic wave_fire_i = 1'b0;
    logic row_load_i = 1'b0;
    logic clear_i = 1'b0;
    logic baseline_i = 1'b0;
    logic [`PHDC_ADDR_W-1:0] wave_addr_i = '0;
    logic [WB-1:0] wave_data_i = '0;
    logic [`PHDC_ROWS-1:0][RB-1:0] row_data_i = '0;
    logic ready_o;
    phdc_common_t common_o;
    phdc_nozzle_t nozzle_o;
    logic [WB-1:0] word;
    logic [`PHDC_ADDR_W-1:0] addr;
    logic [15:0] c1, c2, sh, ld, bits;
    logic [`PHDC_ROWS-1:0][RB-1:0] rows;
    wire [3:0] idle_pins = {common_o.waveform_clock_one, common_o.waveform_clock_two,
        nozzle_o.shift_clock, nozzle_o.row_load_strobe};
    int error_cnt = 0;
    int n_checks = 0;
    always #2 clk_i = ~clk_i;
    initial begin
        #7;
        forever #15 link_clk_i = ~link_clk_i;
    end
    phdc_top #(.ROW_BITS(RB), .WAVE_BITS(WB)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link_clk_i(link_clk_i), .wave_write_i(wave_write_i), .wave_addr_i(wave_addr_i),
        .wave_data_i(wave_data_i), .wave_fire_i(wave_fire_i), .row_load_i(row_load_i),
        .row_data_i(row_data_i), .clear_i(clear_i), .baseline_i(baseline_i),
        .ready_o(ready_o), .common_o(common_o), .nozzle_o(nozzle_o));
    phdc_far_model #(.ROW_BITS(RB), .WAVE_BITS(WB)) far (.common_i(common_o),
        .nozzle_i(nozzle_o), .word_o(word), .addr_o(addr), .pulse_one_cnt_o(c1),
        .pulse_two_cnt_o(c2), .shift_cnt_o(sh), .load_cnt_o(ld), .bits_at_load_o(bits),
        .rows_o(rows));
    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_o !== 1'b1) begin
            if (n == 3000) begin
                $display("wrong value ready_o expected 1 seen %b", ready_o);
                error_cnt++;
                give_verdict();
            end
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    // one request; b pulses a fire while busy, which must be ignored
    task automatic request(input logic w, input logic f, input logic r, input logic b);
        wait_ready();
        wave_write_i = w;
        wave_fire_i = f;
        row_load_i = r;
        @(posedge clk_i);
        #1;
        wave_write_i = 1'b0;
        row_load_i = 1'b0;
        wave_fire_i = b;
        @(posedge clk_i);
        #1;
        wave_fire_i = 1'b0;
        wait_ready();
        chk("idle clocks", 64'h0, {60'h0, idle_pins});
    endtask
    task automatic write_word(input logic [4:0] a, input logic [3:0] d);
        logic [15:0] o1, o2;
        o1 = c1;
        o2 = c2;
        wave_addr_i = a;
        wave_data_i = d;
        request(1'b1, 1'b0, 1'b0, 1'b0);
        chk("address", a, addr);
        chk("word", d, word);
        chk("clock one count", o1 + WB, c1);
        chk("clock two count", o2, c2);
    endtask
    task automatic fire();
        logic [15:0] o1, o2;
        o1 = c1;
        o2 = c2;
        request(1'b0, 1'b1, 1'b0, 1'b0);
        chk("fire clock one", o1 + 16'h1, c1);
        chk("fire clock two", o2 + 16'h1, c2);
    endtask
    // row load beats a write in the same cycle; a fire while busy is dropped
    task automatic load_rows(input logic [47:0] pat);
        logic [15:0] o1, os, ol;
        o1 = c1;
        os = sh;
        ol = ld;
        row_data_i = pat;
        request(1'b1, 1'b0, 1'b1, 1'b1);
        chk("row pattern", pat, rows);
        chk("shift count", os + RB, sh);
        chk("strobe count", ol + 16'h1, ld);
        chk("bits before strobe", RB, bits);
        chk("no waveform clocks", o1, c1);
    endtask
    task automatic levels();
        for (int i = 0; i < 2; i++) begin
            clear_i = i[0];
            baseline_i = !i[0];
            repeat (40) @(posedge clk_i);
            #1;
            chk("clear line", {63'h0, clear_i}, {63'h0, common_o.clear});
            chk("baseline", {63'h0, baseline_i}, {63'h0, common_o.baseline_select});
        end
    endtask
    initial begin
        repeat (25) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        write_word(5'h15, 4'ha);
        write_word(5'h1f, 4'h3);
        write_word(5'h00, 4'h9);
        fire();
        load_rows(48'h815ac30ff03c);
        load_rows(48'h7ea53cf00fc3);
        fire();
        levels();
        give_verdict();
    end
endmodule
`default_nettype wire
